// file: logic/dsam_monitor.sv
// Top of the dual sensor alarm monitor: registers, source selection, indicator pins.
// Assumes a register port on the system clock and a one-cycle sample strobe.
`default_nettype none
module dsam_monitor (
    input  wire logic                                   i_clk,
    input  wire logic                                   i_sys_rst,
    input  wire logic [6:0]                             i_reg_addr,
    input  wire dsam_pkg::dsam_word_t                   i_reg_wdata,
    input  wire logic                                   i_reg_wr,
    input  wire logic                                   i_reg_rd,
    output logic      [15:0]                            o_reg_rdata,
    input  wire logic                                   i_sample_strobe,
    input  wire logic [dsam_pkg::DSAM_NUM_SRC-1:0][15:0] i_raw_data,
    input  wire logic [dsam_pkg::DSAM_NUM_SRC-1:0][15:0] i_filt_data,
    output logic      [1:0]                             o_alarm_flags,
    output logic                                        o_digital_pin_one_out,
    output logic                                        o_digital_pin_one_oe,
    output logic                                        o_digital_pin_two_out,
    output logic                                        o_digital_pin_two_oe
);
    import dsam_pkg::*;

    // ==========================================================================
    // Registers.
    dsam_word_t      alarm_threshold    [0:1];
    logic [7:0]      alarm_sample_count [0:1];
    dsam_word_t      alarm_control;
    dsam_word_t      next_threshold     [0:1];
    logic [7:0]      next_sample_count  [0:1];
    dsam_word_t      next_control;
    logic [15:0]     rdata;
    logic [15:0]     next_rdata;
    logic [1:0]      flags;
    logic [1:0]      chan_flag;
    logic [1:0]      restart;
    logic            pin_one_out;
    logic            pin_one_oe;
    logic            pin_two_out;
    logic            pin_two_oe;
    logic            next_pin_one_out;
    logic            next_pin_one_oe;
    logic            next_pin_two_out;
    logic            next_pin_two_oe;
    logic            wr_ctrl;
    logic [1:0]      next_flags;
    logic [5:0]      hit;

    // ==========================================================================
    // Decoding shared by the write path, the read path and the channels.
    function automatic logic [5:0] reg_hit(input logic [6:0] addr);
        logic [5:0] r;
        r    = 6'h00;
        r[0] = (addr == DSAM_ADDR_THR_ONE);
        r[1] = (addr == DSAM_ADDR_THR_TWO);
        r[2] = (addr == DSAM_ADDR_CNT_ONE);
        r[3] = (addr == DSAM_ADDR_CNT_TWO);
        r[4] = (addr == DSAM_ADDR_CTRL);
        r[5] = (addr == DSAM_ADDR_DIAG);
        return r;
    endfunction : reg_hit

    function automatic logic [3:0] sel_field(input dsam_word_t word, input int ch);
        return word[DSAM_SEL_ONE_LSB + 4*ch +: 4];
    endfunction : sel_field

    assign hit     = reg_hit(i_reg_addr);
    assign wr_ctrl = i_reg_wr && hit[4];

    // ==========================================================================
    // Configuration registers; a write to an unmapped address changes nothing.
    always_comb begin
        next_threshold    = alarm_threshold;
        next_sample_count = alarm_sample_count;
        next_control      = alarm_control;
        if (i_reg_wr && hit[0]) begin
            next_threshold[0] = i_reg_wdata;
        end
        if (i_reg_wr && hit[1]) begin
            next_threshold[1] = i_reg_wdata;
        end
        if (i_reg_wr && hit[2]) begin
            next_sample_count[0] = i_reg_wdata[7:0];
        end
        if (i_reg_wr && hit[3]) begin
            next_sample_count[1] = i_reg_wdata[7:0];
        end
        if (wr_ctrl) begin
            next_control = i_reg_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            alarm_threshold[0]    <= DSAM_RESET_VALUE;
            alarm_threshold[1]    <= DSAM_RESET_VALUE;
            alarm_sample_count[0] <= 8'h00;
            alarm_sample_count[1] <= 8'h00;
            alarm_control         <= DSAM_RESET_VALUE;
        end else begin
            alarm_threshold       <= next_threshold;
            alarm_sample_count    <= next_sample_count;
            alarm_control         <= next_control;
        end
    end

    // ==========================================================================
    // Read path; the data holds until the next read strobe.
    // Only the low eight bits are stored, so the count reads back zero-extended.
    always_comb begin
        next_rdata = rdata;
        if (i_reg_rd) begin
            next_rdata = 16'h0000;
            if (hit[0]) begin
                next_rdata = alarm_threshold[0];
            end
            if (hit[1]) begin
                next_rdata = alarm_threshold[1];
            end
            if (hit[2]) begin
                next_rdata = {8'h00, alarm_sample_count[0]};
            end
            if (hit[3]) begin
                next_rdata = {8'h00, alarm_sample_count[1]};
            end
            if (hit[4]) begin
                next_rdata = alarm_control;
            end
            if (hit[5]) begin
                next_rdata = 16'(flags) << DSAM_DIAG_LSB;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ==========================================================================
    // Two independent channels.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            dsam_chan_if cif ();
            dsam_src_t   src;
            logic [3:0]  new_sel;
            assign src          = dsam_src_decode(sel_field(alarm_control, g));
            assign new_sel      = sel_field(i_reg_wdata, g);
            // Old history belongs to another source, so a change of source restarts it.
            assign restart[g]   = wr_ctrl &&
                                  ((new_sel != sel_field(alarm_control, g)) ||
                                   (i_reg_wdata[DSAM_FILT_BIT] != alarm_control[DSAM_FILT_BIT]));
            assign cif.enable    = src.valid;
            assign cif.dynamic   = alarm_control[DSAM_DYN_ONE_BIT + g];
            assign cif.above     = alarm_control[DSAM_POL_ONE_BIT + g];
            assign cif.threshold = alarm_threshold[g];
            assign cif.count     = alarm_sample_count[g];
            assign cif.value     = alarm_control[DSAM_FILT_BIT] ? i_filt_data[src.index]
                                                                : i_raw_data[src.index];
            assign cif.strobe    = i_sample_strobe;
            assign cif.restart   = restart[g];
            assign chan_flag[g]  = cif.flag;
            dsam_channel u_chan (
                .i_clk     (i_clk),
                .i_sys_rst (i_sys_rst),
                .bus       (cif.chan)
            );
        end
    endgenerate

    // ==========================================================================
    // Status flags, then indicator pins one cycle behind the flags.
    // The pins take the registered flags, so the pin never leads the status bits.
    always_comb begin
        next_flags       = chan_flag;
        next_pin_one_oe  = alarm_control[DSAM_IND_EN_BIT] && !alarm_control[DSAM_IND_PIN_BIT];
        next_pin_two_oe  = alarm_control[DSAM_IND_EN_BIT] && alarm_control[DSAM_IND_PIN_BIT];
        next_pin_one_out = (|flags) ~^ alarm_control[DSAM_IND_POL_BIT];
        next_pin_two_out = next_pin_one_out;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            flags       <= 2'b00;
            pin_one_out <= 1'b0;
            pin_one_oe  <= 1'b0;
            pin_two_out <= 1'b0;
            pin_two_oe  <= 1'b0;
        end else begin
            flags       <= next_flags;
            pin_one_out <= next_pin_one_out;
            pin_one_oe  <= next_pin_one_oe;
            pin_two_out <= next_pin_two_out;
            pin_two_oe  <= next_pin_two_oe;
        end
    end

    assign o_reg_rdata           = rdata;
    assign o_alarm_flags         = flags;
    assign o_digital_pin_one_out = pin_one_out;
    assign o_digital_pin_one_oe  = pin_one_oe;
    assign o_digital_pin_two_out = pin_two_out;
    assign o_digital_pin_two_oe  = pin_two_oe;
endmodule : dsam_monitor
`default_nettype wire

// file: include/dsam_pkg.sv
// Constants, register map and source decoding for the dual sensor alarm monitor.
// Assumes one system clock shared with the register port and the sample strobe.
`default_nettype none
package dsam_pkg;
    // ==========================================================================
    // Register map.
    localparam logic [6:0]  DSAM_ADDR_THR_ONE  = 7'h40;
    localparam logic [6:0]  DSAM_ADDR_THR_TWO  = 7'h42;
    localparam logic [6:0]  DSAM_ADDR_CNT_ONE  = 7'h44;
    localparam logic [6:0]  DSAM_ADDR_CNT_TWO  = 7'h46;
    localparam logic [6:0]  DSAM_ADDR_CTRL     = 7'h48;
    localparam logic [6:0]  DSAM_ADDR_DIAG     = 7'h3C;
    localparam logic [15:0] DSAM_RESET_VALUE   = 16'h0000;
    // ==========================================================================
    // Control field positions.
    localparam int DSAM_SEL_TWO_LSB = 12;
    localparam int DSAM_SEL_ONE_LSB = 8;
    localparam int DSAM_DYN_ONE_BIT = 6;
    localparam int DSAM_POL_ONE_BIT = 4;
    localparam int DSAM_FILT_BIT    = 3;
    localparam int DSAM_IND_EN_BIT  = 2;
    localparam int DSAM_IND_POL_BIT = 1;
    localparam int DSAM_IND_PIN_BIT = 0;
    localparam int DSAM_DIAG_LSB    = 8;
    // ==========================================================================
    // Sources and history.
    localparam int DSAM_NUM_SRC   = 12;
    localparam int DSAM_HIST_LEN  = 256;
    localparam logic [7:0] DSAM_MIN_SPAN = 8'h01;
    localparam logic [7:0] DSAM_MAX_FILL = 8'hFF;

    typedef logic [15:0] dsam_word_t;
    typedef struct packed {
        logic       valid;
        logic [3:0] index;
    } dsam_src_t;

    // Codes 1-7 map to inputs 0-6, codes 9-12 to inputs 7-10; input 11 is never selected and the rest disable.
    function automatic dsam_src_t dsam_src_decode(input logic [3:0] code);
        dsam_src_t r;
        r.valid = 1'b0;
        r.index = 4'h0;
        if (code >= 4'h1 && code <= 4'h7) begin
            r.valid = 1'b1;
            r.index = code - 4'h1;
        end else if (code >= 4'h9 && code <= 4'hC) begin
            r.valid = 1'b1;
            r.index = code - 4'h2;
        end
        return r;
    endfunction : dsam_src_decode
endpackage : dsam_pkg
`default_nettype wire

// file: include/dsam_chan_if.sv
// Connection between the monitor top and one alarm channel.
// Assumes both ends share the system clock.
`default_nettype none
interface dsam_chan_if;
    import dsam_pkg::*;
    logic       enable;
    logic       dynamic;
    logic       above;
    dsam_word_t threshold;
    logic [7:0] count;
    dsam_word_t value;
    logic       strobe;
    logic       restart;
    logic       flag;
    modport top  (output enable, dynamic, above, threshold, count, value, strobe, restart,
                  input flag);
    modport chan (input enable, dynamic, above, threshold, count, value, strobe, restart,
                  output flag);
endinterface : dsam_chan_if
`default_nettype wire

// file: logic/dsam_channel.sv
// One alarm channel: static level or rate-of-change comparison per sample.
// Assumes the top supplies the selected value and a one-cycle sample strobe.
`default_nettype none
module dsam_channel (
    input wire logic  i_clk,
    input wire logic  i_sys_rst,
    dsam_chan_if.chan bus
);
    import dsam_pkg::*;

    // ==========================================================================
    // History of past samples.
    dsam_word_t       hist [0:DSAM_HIST_LEN-1];
    logic [7:0]       wptr;
    logic [7:0]       fill;
    logic             flag;
    logic [7:0]       next_wptr;
    logic [7:0]       next_fill;
    logic             next_flag;
    logic [7:0]       span;
    dsam_word_t       older;
    logic signed [16:0] delta;
    logic [16:0]      mag;
    logic             result;

    always_comb begin
        span  = (bus.count <= DSAM_MIN_SPAN) ? DSAM_MIN_SPAN : bus.count;
        older = hist[8'(wptr - span)];
        delta = $signed({bus.value[15], bus.value}) - $signed({older[15], older});
        mag   = delta[16] ? 17'(-delta) : 17'(delta);
        if (bus.dynamic) begin
            // Until enough history exists the change is unknown, so no alarm.
            result = (fill >= span) &&
                     (bus.above ? (mag > {1'b0, bus.threshold})
                                : (mag < {1'b0, bus.threshold}));
        end else begin
            result = bus.above ? ($signed(bus.value) > $signed(bus.threshold))
                               : ($signed(bus.value) < $signed(bus.threshold));
        end
        next_wptr = wptr;
        next_fill = fill;
        next_flag = flag;
        if (bus.strobe) begin
            next_wptr = wptr + 8'h01;
            next_flag = bus.enable && result;
            if (fill != DSAM_MAX_FILL) begin
                next_fill = fill + 8'h01;
            end
        end
        if (bus.restart) begin
            next_fill = 8'h00;
        end
        if (!bus.enable) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wptr <= 8'h00;
            fill <= 8'h00;
            flag <= 1'b0;
        end else begin
            wptr <= next_wptr;
            fill <= next_fill;
            flag <= next_flag;
        end
        if (bus.strobe) begin
            hist[wptr] <= bus.value;
        end
    end

    assign bus.flag = flag;
endmodule : dsam_channel
`default_nettype wire

// file: tb/dsam_monitor_sva.sv
// Checker for the alarm monitor top, bound to its ports.
// Assumes control writes land on the edge that samples the write strobe.
`default_nettype none
module dsam_monitor_sva (
    input wire logic                 i_clk,
    input wire logic                 i_sys_rst,
    input wire logic [6:0]           i_reg_addr,
    input wire dsam_pkg::dsam_word_t i_reg_wdata,
    input wire logic                 i_reg_wr,
    input wire logic                 i_reg_rd,
    input wire logic [15:0]          o_reg_rdata,
    input wire logic                 i_sample_strobe,
    input wire logic [1:0]           o_alarm_flags,
    input wire logic                 o_digital_pin_one_out,
    input wire logic                 o_digital_pin_one_oe,
    input wire logic                 o_digital_pin_two_out,
    input wire logic                 o_digital_pin_two_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    import dsam_pkg::*;
    logic [15:0] ctrl_h;
    logic        pin_sel;
    // ==========
    // Control mirror and assertions.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst)
            ctrl_h <= 16'h0000;
        else if (i_reg_wr && i_reg_addr == DSAM_ADDR_CTRL)
            ctrl_h <= i_reg_wdata;
    end
    assign pin_sel = ctrl_h[0] ? o_digital_pin_two_out : o_digital_pin_one_out;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_flags_on_sample: assert property ($changed(o_alarm_flags) |->
        $past(i_sample_strobe, 2) || $past(i_reg_wr, 3))
        else $error("Flags moved without a sample.");
    a_pin_off: assert property ((!ctrl_h[2])[*3] |-> !o_digital_pin_one_oe && !o_digital_pin_two_oe)
        else $error("Indicator driven while disabled.");
    a_pin_select: assert property ((ctrl_h[2] && $stable(ctrl_h))[*3] |->
        o_digital_pin_two_oe == ctrl_h[0] && o_digital_pin_one_oe != ctrl_h[0])
        else $error("Indicator on the wrong pin.");
    a_pin_level: assert property ((ctrl_h[2] && $stable(ctrl_h))[*3] |->
        pin_sel == ((|$past(o_alarm_flags)) ~^ ctrl_h[1]))
        else $error("Indicator level wrong.");
    a_diag_read: assert property (i_reg_rd && i_reg_addr == DSAM_ADDR_DIAG |=>
        o_reg_rdata == {6'h00, $past(o_alarm_flags), 8'h00})
        else $error("Status read does not show flags.");
    a_count_high: assert property (i_reg_rd && (i_reg_addr == DSAM_ADDR_CNT_ONE ||
        i_reg_addr == DSAM_ADDR_CNT_TWO) |=> o_reg_rdata[15:8] == 8'h00)
        else $error("Sample count upper byte not zero.");
    a_sel_off_one: assert property (i_sample_strobe &&
        (ctrl_h[11:8] inside {4'h0, 4'h8, 4'hD, 4'hE, 4'hF}) |-> ##2 !o_alarm_flags[0])
        else $error("Disabled alarm one raised.");
    a_sel_off_two: assert property (i_sample_strobe &&
        (ctrl_h[15:12] inside {4'h0, 4'h8, 4'hD, 4'hE, 4'hF}) |-> ##2 !o_alarm_flags[1])
        else $error("Disabled alarm two raised.");
    c_alarm_one: cover property ($rose(o_alarm_flags[0]));
    c_alarm_two: cover property ($rose(o_alarm_flags[1]));
    c_pin_two: cover property (o_digital_pin_two_oe && o_digital_pin_two_out);
endmodule : dsam_monitor_sva
bind dsam_monitor dsam_monitor_sva u_dsam_monitor_sva (.i_clk, .i_sys_rst, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_sample_strobe, .o_alarm_flags,
    .o_digital_pin_one_out, .o_digital_pin_one_oe, .o_digital_pin_two_out,
    .o_digital_pin_two_oe);
`default_nettype wire

// file: tb/dsam_host_model.sv
// Host processor model driving the monitor's register port.
// Assumes each task is entered in the time step of a rising clock edge.
`default_nettype none
module dsam_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output var  logic [6:0]  o_addr,
    output var  logic [15:0] o_wdata,
    output var  logic        o_wr,
    output var  logic        o_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // Accesses end one idle edge late, so a strobe is never dropped and raised in one step.
    initial begin
        o_addr  = 7'h00;
        o_wdata = 16'h0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk) o_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [6:0] a, output logic [15:0] d);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk) o_rd <= 1'b0;
        @(posedge i_clk) d = i_rdata;
    endtask : rd_reg
endmodule : dsam_host_model
`default_nettype wire

// file: tb/dsam_monitor_test.sv
// Self-checking bench for the dual sensor alarm monitor.
// Assumes the host model performs every register access.
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module dsam_monitor_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dsam_pkg::*;
    logic              i_clk = 1'b0;
    logic              i_sys_rst = 1'b1;
    logic              strobe = 1'b0;
    logic [11:0][15:0] raw = '0;
    logic [11:0][15:0] filt = '0;
    logic [6:0]        addr;
    logic [15:0]       wdata, rdata;
    logic              wr, rd, p1, p1_oe, p2, p2_oe;
    logic [1:0]        flags;
    int                err_total = 0;
    int                check_count = 0;
    always #25 i_clk = ~i_clk;
    dsam_host_model u_dsam_host_model (.i_clk, .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    dsam_monitor u_dsam_monitor (.i_clk, .i_sys_rst, .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_sample_strobe(strobe),
        .i_raw_data(raw), .i_filt_data(filt), .o_alarm_flags(flags),
        .o_digital_pin_one_out(p1), .o_digital_pin_one_oe(p1_oe),
        .o_digital_pin_two_out(p2), .o_digital_pin_two_oe(p2_oe));
    // ==========
    // Shared steps.
    task automatic w(input logic [6:0] a, input logic [15:0] d);
        u_dsam_host_model.wr_reg(a, d);
    endtask : w
    task automatic chk_rd(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] v;
        u_dsam_host_model.rd_reg(a, v);
        `CHK(v, e)
    endtask : chk_rd
    task automatic samp();
        strobe <= 1'b1;
        @(posedge i_clk) strobe <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask : samp
    // ==========
    // Scenarios.
    task automatic t_regs();
        logic [6:0] map [6] = '{DSAM_ADDR_THR_ONE, DSAM_ADDR_THR_TWO, DSAM_ADDR_CNT_ONE,
            DSAM_ADDR_CNT_TWO, DSAM_ADDR_CTRL, DSAM_ADDR_DIAG};
        foreach (map[i]) chk_rd(map[i], 16'h0000);
        w(DSAM_ADDR_CNT_ONE, 16'hABCD);
        chk_rd(DSAM_ADDR_CNT_ONE, 16'h00CD);
        w(DSAM_ADDR_THR_TWO, 16'h8421);
        chk_rd(DSAM_ADDR_THR_TWO, 16'h8421);
        w(7'h4A, 16'hFFFF);
        chk_rd(7'h4A, 16'h0000);
    endtask : t_regs
    task automatic t_codes();
        logic [11:0][15:0] v;
        w(DSAM_ADDR_THR_TWO, 16'h0000);
        for (int k = 1; k < 13; k++) begin
            v = '0;
            if (k != 8) v[(k < 8) ? k - 1 : k - 2] = 16'h0100;
            raw <= v;
            w(DSAM_ADDR_CTRL, {4'(k), 4'(k), 8'h30});
            samp();
            `CHK(flags, (k == 8) ? 2'h0 : 2'h3)
        end
    endtask : t_codes
    task automatic t_static();
        logic [11:0][15:0] v;
        v = '0;
        v[5] = 16'h0400;
        raw <= v;
        v[5] = 16'h0300;
        filt <= v;
        w(DSAM_ADDR_THR_ONE, 16'h0348);
        w(DSAM_ADDR_CTRL, 16'h060F);
        samp();
        `CHK({flags, p2_oe, p2, p1_oe}, 5'h0E)
        chk_rd(DSAM_ADDR_DIAG, 16'h0100);
        w(DSAM_ADDR_CTRL, 16'h0606);
        samp();
        `CHK({flags, p1_oe, p1, p2_oe}, 5'h04)
        w(DSAM_ADDR_CTRL, 16'h060C);
        samp();
        `CHK({flags, p1_oe, p1, p2_oe}, 5'h0C)
        w(DSAM_ADDR_CTRL, 16'h0608);
        samp();
        `CHK({flags, p1_oe, p2_oe}, 4'h4)
    endtask : t_static
    task automatic t_dyn();
        logic [11:0][15:0] v;
        v = '0;
        raw <= v;
        w(DSAM_ADDR_CNT_TWO, 16'h0002);
        w(DSAM_ADDR_THR_TWO, 16'h0010);
        w(DSAM_ADDR_CTRL, 16'h30A0);
        repeat (4) samp();
        `CHK(flags, 2'h0)
        v[2] = 16'h0020;
        raw <= v;
        samp();
        `CHK(flags, 2'h2)
        repeat (3) samp();
        `CHK(flags, 2'h0)
        w(DSAM_ADDR_CNT_TWO, 16'h0000);
        samp();
        v[2] = 16'h0040;
        raw <= v;
        samp();
        `CHK(flags, 2'h2)
        samp();
        `CHK(flags, 2'h0)
    endtask : t_dyn
    task automatic end_sim();
        $display("Checks %0d, errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    initial begin
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        t_regs();
        t_codes();
        t_static();
        t_dyn();
        end_sim();
    end
    // Tests need well under 1000 cycles; the margin covers a slow design.
    initial begin
        repeat (5000) @(posedge i_clk);
        err_total++;
        end_sim();
    end
endmodule : dsam_monitor_test
`default_nettype wire
